// ==== design/bor_port.sv ====
// top of the bus output register port: decode, 64 outputs, control bits
// assumes switch and jumper pins are asynchronous; bus port is on clock_i
`timescale 1ns/100ps
module bor_port
(
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    input  wire bor_pkg::bor_req_t         req_i,
    input  wire logic                      address_space_jumper_i,
    input  wire logic [bor_pkg::ADDR_W-1:0] data_base_i,
    input  wire logic [bor_pkg::ADDR_W-1:0] csr_base_i,
    output logic      [bor_pkg::DATA_W-1:0] rdata_o,
    output logic                           ack_o,
    output logic [bor_pkg::NBYTES*bor_pkg::BYTE_W-1:0] out_o,
    output logic                           out_en_o,
    output logic                           fail_led_o
);
    import bor_pkg::*;

    // two-flop synchronisers for switch and jumper pins
    logic              jmp_s1_ff;
    logic              jmp_ff;
    logic [ADDR_W-1:0] dbase_s1_ff;
    logic [ADDR_W-1:0] dbase_ff;
    logic [ADDR_W-1:0] cbase_s1_ff;
    logic [ADDR_W-1:0] cbase_ff;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            jmp_s1_ff   <= 1'b0;
            jmp_ff      <= 1'b0;
            dbase_s1_ff <= '0;
            dbase_ff    <= '0;
            cbase_s1_ff <= '0;
            cbase_ff    <= '0;
        end else begin
            jmp_s1_ff   <= address_space_jumper_i;
            jmp_ff      <= jmp_s1_ff;
            dbase_s1_ff <= data_base_i;
            dbase_ff    <= dbase_s1_ff;
            cbase_s1_ff <= csr_base_i;
            cbase_ff    <= cbase_s1_ff;
        end
    end

    // access type and region decode
    logic am_ok;
    logic hit_data;
    logic hit_csr;
    logic hit;
    logic access;

    always_comb begin
        am_ok    = jmp_ff ? (req_i.am == AM_SHORT_USER)
                          : (req_i.am == AM_SHORT_SUPER);
        hit_data = am_ok && (req_i.addr[ADDR_W-1:DEC_LO] == dbase_ff[ADDR_W-1:DEC_LO]);
        hit_csr  = am_ok && !hit_data
                   && (req_i.addr[ADDR_W-1:DEC_LO] == cbase_ff[ADDR_W-1:DEC_LO]);
        hit      = hit_data || hit_csr;
        access   = req_i.wr || req_i.rd;
    end

    // eight output data registers, big-endian lanes within a longword
    logic [NBYTES-1:0]        odr_we;
    logic [BYTE_W-1:0]        odr_d  [NBYTES];
    logic [BYTE_W-1:0]        odr_q  [NBYTES];

    genvar gi;
    generate
        for (gi = 0; gi < NBYTES; gi++) begin : g_odr
            localparam int LANE = LANES - 1 - (gi % LANES);
            localparam int LW   = gi / LANES;
            assign odr_we[gi] = req_i.wr && hit_data
                                && (req_i.addr[LW_BIT] == LW[0])
                                && req_i.be[LANE];
            assign odr_d[gi]  = req_i.wdata[LANE*BYTE_W +: BYTE_W];
            bor_byte_reg #(
                .W     (BYTE_W),
                .RST_V (ODR_RESET)
            ) u_odr (
                .clock_i (clock_i),
                .rst_i   (rst_i),
                .we_i    (odr_we[gi]),
                .d_i     (odr_d[gi]),
                .q_o     (odr_q[gi])
            );
            assign out_o[gi*BYTE_W +: BYTE_W] = odr_q[gi];
        end
    endgenerate

    // write-only control bits
    logic csr_wr;
    assign csr_wr = req_i.wr && hit_csr && req_i.be[CSR_LANE];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            out_en_o   <= DRV_EN_RST;
            fail_led_o <= FAIL_RST;
        end else if (csr_wr) begin
            out_en_o   <= !req_i.wdata[CSR_TEST_BIT];
            fail_led_o <= req_i.wdata[CSR_FAIL_BIT];
        end
    end

    // read data: data registers read back, control reads as zero
    logic [DATA_W-1:0] nxt_rdata;

    always_comb begin
        nxt_rdata = RDATA_IDLE;
        if (req_i.rd && hit_data) begin
            for (int k = 0; k < LANES; k++) begin
                if (req_i.be[k]) begin
                    nxt_rdata[k*BYTE_W +: BYTE_W] =
                        odr_q[{req_i.addr[LW_BIT], 2'(LANES - 1 - k)}];
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= RDATA_IDLE;
            ack_o   <= 1'b0;
        end else begin
            rdata_o <= nxt_rdata;
            ack_o   <= access && hit;
        end
    end

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_lw_write;
        req_i.wr && hit_data && (req_i.be == 4'hF);
    endsequence

    sequence s_same_read;
        req_i.rd && hit_data && (req_i.be == 4'hF)
            && (req_i.addr[LW_BIT] == $past(req_i.addr[LW_BIT]));
    endsequence

    sequence s_test_write;
        csr_wr && req_i.wdata[CSR_TEST_BIT];
    endsequence

    sequence s_test_lw_write;
        !out_en_o && req_i.wr && hit_data && (req_i.be == 4'hF);
    endsequence

    // bus answer and decode
    a_ack_on_hit: assert property (access && hit |=> ack_o)
        else $error("hit not acknowledged");
    a_quiet_miss: assert property (!(access && hit)
                                   |=> !ack_o && rdata_o == RDATA_IDLE)
        else $error("answer without a hit");
    a_am_filter: assert property (access && !am_ok |=> !ack_o)
        else $error("wrong modifier acknowledged");
    a_super_default: assert property (!jmp_ff && req_i.am == AM_SHORT_USER |-> !hit)
        else $error("user access hit without jumper");
    a_user_only: assert property (jmp_ff && req_i.am == AM_SHORT_SUPER |-> !hit)
        else $error("supervisory access hit with jumper");
    a_rdata_idle: assert property (!(req_i.rd && hit_data)
                                   |=> rdata_o == RDATA_IDLE)
        else $error("read data outside a data read");

    // control bits
    a_reset_state: assert property (@(posedge clock_i) disable iff (1'b0)
                                    rst_i |=> fail_led_o && !out_en_o)
        else $error("control bits not set by reset");
    a_fail_hold: assert property (fail_led_o && !csr_wr |=> fail_led_o)
        else $error("fault led dropped without a write");
    a_csr_clear: assert property (csr_wr && !req_i.wdata[CSR_FAIL_BIT]
                                  && !req_i.wdata[CSR_TEST_BIT]
                                  |=> !fail_led_o && out_en_o)
        else $error("zero write did not clear control");
    a_led_set: assert property (csr_wr && req_i.wdata[CSR_FAIL_BIT] |=> fail_led_o)
        else $error("fault led not set by write");
    a_test_set: assert property (s_test_write |=> !out_en_o)
        else $error("test mode not entered by write");
    a_test_hold: assert property (!out_en_o && !csr_wr |=> !out_en_o)
        else $error("drivers enabled while in test");

    // output registers
    a_lw_readback: assert property (s_lw_write ##1 s_same_read |=>
                                    rdata_o == $past(req_i.wdata, 2))
        else $error("longword read back mismatch");
    a_test_readback: assert property (s_test_lw_write ##1 s_same_read |=>
                                      !out_en_o && rdata_o == $past(req_i.wdata, 2))
        else $error("test mode write not read back");
    a_byte_store: assert property (odr_we[0]
                                   |=> out_o[BYTE_W-1:0] == $past(odr_d[0]))
        else $error("byte write not stored");
    a_lw_select: assert property (req_i.wr && hit_data && !req_i.addr[LW_BIT]
                                  |=> $stable(out_o[NBYTES*BYTE_W-1:LANES*BYTE_W]))
        else $error("low longword write touched high bytes");
    a_keep_outputs: assert property (!(req_i.wr && hit_data) |=> $stable(out_o))
        else $error("outputs changed without a data write");
    a_ctl_no_store: assert property (req_i.wr && hit_csr |=> $stable(out_o))
        else $error("control write changed outputs");
    a_lane0_zero: assert property (req_i.rd && hit_data && !req_i.be[0]
                                   |=> rdata_o[BYTE_W-1:0] == '0)
        else $error("disabled low lane returned data");
    a_lane3_zero: assert property (req_i.rd && hit_data && !req_i.be[LANES-1]
                                   |=> rdata_o[DATA_W-1 -: BYTE_W] == '0)
        else $error("disabled high lane returned data");
    a_csr_reads_zero: assert property (req_i.rd && hit_csr
                                       |=> rdata_o == RDATA_IDLE && ack_o)
        else $error("control register read returned data");
endmodule

// ==== common/bor_pkg.sv ====
// package for the bus output register port: widths, codes, bit positions
// assumes a short i/o backplane bus seen through a plain register port
package bor_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int AM_W   = 6;
    localparam int LANES  = 4;
    localparam int NBYTES = 8;
    localparam int BYTE_W = 8;
    localparam int DEC_LO = 3;
    localparam int LW_BIT = 2;

    localparam logic [AM_W-1:0] AM_SHORT_SUPER = 6'h2D;
    localparam logic [AM_W-1:0] AM_SHORT_USER  = 6'h29;

    localparam int CSR_TEST_BIT = 7;
    localparam int CSR_FAIL_BIT = 6;
    localparam int CSR_LANE     = 0;

    localparam logic [BYTE_W-1:0] ODR_RESET   = 8'h00;
    localparam logic              DRV_EN_RST  = 1'b0;
    localparam logic              FAIL_RST    = 1'b1;
    localparam logic [DATA_W-1:0] RDATA_IDLE  = 32'h0000_0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [AM_W-1:0]   am;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0]  be;
        logic              wr;
        logic              rd;
    } bor_req_t;
endpackage

// ==== design/bor_byte_reg.sv ====
// one byte-wide output data register with write enable and read back
// assumes synchronous active-high reset on the same clock
`timescale 1ns/100ps
module bor_byte_reg #(
    parameter int                W     = 8,
    parameter logic [W-1:0]      RST_V = '0
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic         we_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q_o <= RST_V;
        end else if (we_i) begin
            q_o <= d_i;
        end
    end
endmodule

// ==== bench/bor_master.sv ====
// bus master model: drives the port's request struct
// assumes the port answers one cycle after a taken strobe and never waits
`timescale 1ns/100ps
module bor_master
(
    input  wire logic                       clock_i,
    input  wire logic                       ack_i,
    input  wire logic [bor_pkg::DATA_W-1:0] rdata_i,
    output bor_pkg::bor_req_t               req_o
);
    import bor_pkg::*;
    initial req_o = '0;
    // one strobe cycle, answer taken in the cycle after
    task automatic cyc(input logic w, input logic [15:0] a, input logic [5:0] m,
                       input logic [31:0] d, input logic [3:0] b,
                       output logic [31:0] rdo, output logic ako);
        @(posedge clock_i);
        req_o <= '{addr: a, am: m, wdata: d, be: b, wr: w, rd: !w};
        @(posedge clock_i);
        req_o.wr <= 1'h0;
        req_o.rd <= 1'h0;
        req_o.addr <= ~a;
        req_o.wdata <= ~d;
        #1;
        rdo = rdata_i;
        ako = ack_i;
    endtask
    // longword write, then a read of it with no gap; answer of the read
    task automatic wr_then_rd(input logic [15:0] a, input logic [5:0] m, input logic [31:0] d,
                              output logic [31:0] rdo, output logic ako);
        @(posedge clock_i);
        req_o <= '{addr: a, am: m, wdata: d, be: 4'hF, wr: 1'h1, rd: 1'h0};
        @(posedge clock_i);
        req_o.wr <= 1'h0;
        req_o.rd <= 1'h1;
        @(posedge clock_i);
        req_o.rd <= 1'h0;
        #1;
        rdo = rdata_i;
        ako = ack_i;
    endtask
endmodule

// ==== bench/bor_port_bench.sv ====
// testbench for the bus output register port
// assumes bor_master as the bus master; data base 1000, control base 2000
`timescale 1ns/100ps
module bor_port_bench;
    import bor_pkg::*;
    logic        clock_i, rst_i, jmp, ack, led, oen, ak;
    logic [15:0] dbase, cbase;
    logic [31:0] rdata, rd;
    logic [63:0] outs, exp_out;
    bor_req_t    req;
    int          err_total, check_count;
    localparam logic [5:0] SU = AM_SHORT_SUPER;
    bor_port bor_port_i (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
        .address_space_jumper_i(jmp), .data_base_i(dbase), .csr_base_i(cbase),
        .rdata_o(rdata), .ack_o(ack), .out_o(outs), .out_en_o(oen), .fail_led_o(led));
    bor_master bor_master_i (.clock_i(clock_i), .ack_i(ack), .rdata_i(rdata), .req_o(req));
    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [5:0] m, input logic [31:0] d,
                      input logic [3:0] b, input logic want_ack);
        bor_master_i.cyc(1'h1, a, m, d, b, rd, ak);
        chk(ak, want_ack);
        chk(outs, exp_out);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [5:0] m, input logic [3:0] b,
                       input logic want_ack, input logic [31:0] want);
        bor_master_i.cyc(1'h0, a, m, 32'h0, b, rd, ak);
        chk(ak, want_ack);
        chk(rd, want);
    endtask
    task automatic t_reset;
        chk(outs, 64'h0);
        chk(oen, 1'h0);
        chk(led, 1'h1);
    endtask
    task automatic t_test_mode;
        exp_out[31:0] = 32'h44332211;
        wr(16'h1000, SU, 32'h11223344, 4'hF, 1'h1);
        chk(oen, 1'h0);
        chk(led, 1'h1);
        rdc(16'h1000, SU, 4'hF, 1'h1, 32'h11223344);
    endtask
    task automatic t_widths;
        exp_out[47:32] = 16'hB6A5;
        wr(16'h1006, SU, 32'hA5B60000, 4'hC, 1'h1);
        exp_out[63:56] = 8'hC7;
        wr(16'h1005, SU, 32'h000000C7, 4'h1, 1'h1);
        rdc(16'h1004, SU, 4'hF, 1'h1, 32'hA5B600C7);
        rdc(16'h1002, SU, 4'h3, 1'h1, 32'h00003344);
        rdc(16'h1000, SU, 4'hC, 1'h1, 32'h11220000);
    endtask
    task automatic t_back2back;
        exp_out[63:32] = 32'h04030201;
        bor_master_i.wr_then_rd(16'h1004, SU, 32'h01020304, rd, ak);
        chk(ak, 1'h1);
        chk(rd, 32'h01020304);
        chk(outs, exp_out);
    endtask
    task automatic t_csr;
        wr(16'h2000, SU, 32'h0, 4'h1, 1'h1);
        chk({oen, led}, 2'h2);
        rdc(16'h2004, SU, 4'hF, 1'h1, 32'h0);
        wr(16'h2000, SU, 32'h80, 4'h1, 1'h1);
        chk({oen, led}, 2'h0);
        wr(16'h2000, SU, 32'h40, 4'h1, 1'h1);
        chk({oen, led}, 2'h3);
    endtask
    task automatic t_rereset;
        @(posedge clock_i);
        rst_i <= 1'h1;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'h0;
        exp_out = 64'h0;
        @(posedge clock_i);
        #1;
        chk(outs, exp_out);
        chk({oen, led}, 2'h1);
        repeat (2) @(posedge clock_i);
    endtask
    task automatic t_refuse;
        wr(16'h1000, AM_SHORT_USER, 32'hFFFFFFFF, 4'hF, 1'h0);
        wr(16'h3000, SU, 32'hFFFFFFFF, 4'hF, 1'h0);
        wr(16'h1000, 6'h39, 32'hFFFFFFFF, 4'hF, 1'h0);
        rdc(16'h1008, SU, 4'hF, 1'h0, 32'h0);
        @(posedge clock_i);
        jmp <= 1'h1;
        repeat (4) @(posedge clock_i);
        rdc(16'h1000, SU, 4'hF, 1'h0, 32'h0);
        exp_out[7:0] = 8'h5A;
        wr(16'h1000, AM_SHORT_USER, 32'h5A000000, 4'h8, 1'h1);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clock_i = 1'h0;
        forever #2 clock_i = ~clock_i;
    end
    initial begin
        #20000;
        err_total++;
        close_out();
    end
    initial begin
        {rst_i, jmp, dbase, cbase, exp_out} = {1'h1, 1'h0, 16'h1000, 16'h2000, 64'h0};
        repeat (4) @(posedge clock_i);
        rst_i <= 1'h0;
        repeat (3) @(posedge clock_i);
        t_reset();
        t_test_mode();
        t_widths();
        t_back2back();
        t_csr();
        t_rereset();
        t_refuse();
        close_out();
    end
endmodule
